// *** inc/rcs_regs.svh ***
// Timing constants and command codes for the reference clock selector
`ifndef RCS_REGS_SVH
`define RCS_REGS_SVH
`define RCS_CLK_HZ 100000000
`define RCS_HOLDOFF_S 10
`define RCS_HOLDOFF_CYC (`RCS_HOLDOFF_S * `RCS_CLK_HZ)
`define RCS_SELFTEST_US 100
`define RCS_SELFTEST_CYC (`RCS_SELFTEST_US * (`RCS_CLK_HZ / 1000000))
`define RCS_SANITY_MS 500
`define RCS_SANITY_CYC (`RCS_SANITY_MS * (`RCS_CLK_HZ / 1000))
`define RCS_SANITY_PULSE 16
`define RCS_BLINK_MS 250
`define RCS_BLINK_CYC (`RCS_BLINK_MS * (`RCS_CLK_HZ / 1000))
`define RCS_CMD_NONE 2'h0
`define RCS_CMD_PRI 2'h1
`define RCS_CMD_SEC 2'h2
`define RCS_CMD_FREE 2'h3
`define RCS_LED_OFF 2'h0
`define RCS_LED_RED 2'h1
`define RCS_LED_GREEN 2'h2
`endif

// *** inc/rcs_pkg.sv ***
// Types shared by the reference clock selector
`default_nettype none
package rcs_pkg;
  typedef enum logic [2:0] {
    RCS_ST_DISABLED,
    RCS_ST_SELFTEST,
    RCS_ST_FREERUN,
    RCS_ST_TRACK_PRI,
    RCS_ST_TRACK_SEC,
    RCS_ST_HOLDOVER
  } rcs_state_t;
  typedef enum logic {
    RCS_PRIMARY_SYNC_SOURCE_PRI,
    RCS_PRIMARY_SYNC_SOURCE_SEC
  } rcs_primary_sync_source_t;
endpackage
`default_nettype wire

// *** rtl/rcs_sanity_timer.sv ***
// Sanity timer that resets the embedded controller when not serviced
`default_nettype none
`include "rcs_regs.svh"
module rcs_sanity_timer #(
  parameter int unsigned TIMEOUT_CYC = `RCS_SANITY_CYC
) (
  input wire logic i_sys_clk,     // System clock
  input wire logic i_rst_n,       // Synchronised reset
  input wire logic i_kick,        // Service pulse from the controller
  output logic o_ctrl_reset       // Reset pulse to the controller
);
  logic [31:0] cnt_q;
  logic [4:0] pulse_q;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= 32'h0;
    end else if (i_kick || cnt_q == TIMEOUT_CYC - 1) begin
      cnt_q <= 32'h0;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pulse_q <= 5'h0;
    end else if (!i_kick && cnt_q == TIMEOUT_CYC - 1) begin
      pulse_q <= 5'(`RCS_SANITY_PULSE);
    end else if (pulse_q != 5'h0) begin
      pulse_q <= pulse_q - 5'h1;
    end
  end

  assign o_ctrl_reset = (pulse_q != 5'h0);

  a_sanity_fires: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (!i_kick && cnt_q == TIMEOUT_CYC - 1) |=> o_ctrl_reset)
    else $error("sanity timer did not fire");
endmodule // rcs_sanity_timer
`default_nettype wire

// *** rtl/rcs_reference_clock_selector.sv ***
// Reference selection, holdover and free-run control
// Functional notes
// - Both references' quality is watched at all times, whichever is used.
// - Selected reference bad, other good: switch by itself at once.
// - Both bad: holdover, keep watching both for recovery.
// - Track-primary command selects primary; falls back to good secondary.
// - Primary preferred, secondary recovers first: track it, return later.
// - Primary preferred, primary recovers first: stay on primary.
// - Track-secondary command selects secondary; falls back to primary.
// - Secondary preferred: mirror of primary-preferred recovery behaviour.
// - No further automatic switch for at least ten seconds after one.
// - Momentary loss or error burst gives temporary holdover.
// - Free-run instead of holdover when no quality history is stored.
// - Free-run command stays in free-run until another command.
// - Enable puts the block in free-run without a command.
// - Loop error value is followed, frozen in holdover, or adjusted.
// - Sanity timer resets the controller when not serviced.
// - Self-test runs during initialisation before tracking.
// - Only one trunk card drives the shared backplane line at a time.
// - Primary is host card, secondary one configured card, nothing else.
// - External pair or trunk pair is used, never a mixture.
// - Commands and status pass over the parallel command port.
// - LED red when disabled, green locked or free, flashing in holdover or unlocked tracking.
`default_nettype none
`include "rcs_regs.svh"
module rcs_reference_clock_selector #(
  parameter int unsigned HOLDOFF_CYC = `RCS_HOLDOFF_CYC,
  parameter int unsigned SELFTEST_CYC = `RCS_SELFTEST_CYC,
  parameter int unsigned SANITY_CYC = `RCS_SANITY_CYC,
  parameter int unsigned BLINK_CYC = `RCS_BLINK_CYC
) (
  input wire logic i_sys_clk,           // System clock, 100 MHz
  input wire logic i_reset_n,           // Asynchronous reset, active low
  input wire logic i_enable,            // Controller enabled (pin)
  input wire logic i_cmd_valid,         // Command strobe, one cycle
  input wire logic [1:0] i_cmd,         // Command code
  input wire logic i_use_external,      // Use external pair (pin)
  input wire logic [1:0] i_sec_card,    // Configured secondary card slot
  input wire logic i_pri_in_spec,       // Primary quality good (pin)
  input wire logic i_sec_in_spec,       // Secondary quality good (pin)
  input wire logic i_ext_pri_in_spec,   // External primary good (pin)
  input wire logic i_ext_sec_in_spec,   // External secondary good (pin)
  input wire logic i_pri_present,       // Primary signal present (pin)
  input wire logic i_sec_present,       // Secondary signal present (pin)
  input wire logic i_burst,             // Error burst seen (pin)
  input wire logic i_selftest_ok,       // Self-test result (pin)
  input wire logic i_loop_adjust,       // Controller adjust strobe
  input wire logic [15:0] i_loop_error, // Digital loop error value
  input wire logic [15:0] i_loop_delta, // Controller adjustment value
  input wire logic i_ctrl_kick,         // Controller services sanity timer
  output rcs_pkg::rcs_state_t o_state,  // Current state
  output logic o_ref_sel_sec,           // 1 = secondary reference used
  output logic o_ref_sel_ext,           // 1 = external pair used
  output logic [3:0] o_line_drive_en,   // One-hot card drive enables
  output logic [15:0] o_osc_ctrl,       // Oscillator steering value
  output logic [7:0] o_status,          // Status word to host
  output logic o_selftest_fail,         // Self-test failed
  output logic o_ctrl_reset,            // Embedded controller reset
  output logic o_led_red,               // LED red
  output logic o_led_green              // LED green
);
  import rcs_pkg::*;

  logic rst_meta_q, rst_q;
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_q <= rst_meta_q;
    end
  end
  wire logic rst_n = rst_q;

  // Pin inputs through two flip-flops
  localparam int NPIN = 10;
  logic [NPIN-1:0] pin_meta_q, pin_q;
  wire logic [NPIN-1:0] pin_raw = {i_enable, i_use_external, i_pri_in_spec,
    i_sec_in_spec, i_ext_pri_in_spec, i_ext_sec_in_spec, i_pri_present,
    i_sec_present, i_burst, i_selftest_ok};
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_q <= '0;
      pin_q <= '0;
    end else begin
      pin_meta_q <= pin_raw;
      pin_q <= pin_meta_q;
    end
  end
  wire logic en_s = pin_q[9];
  wire logic ext_s = pin_q[8];
  // Never mix the pairs: both qualities come from one pair
  wire logic pri_ok = (ext_s ? pin_q[5] : pin_q[7]) && pin_q[3];
  wire logic sec_ok = (ext_s ? pin_q[4] : pin_q[6]) && pin_q[2];
  wire logic burst_s = pin_q[1];
  wire logic st_ok_s = pin_q[0];

  rcs_state_t state_q;
  rcs_primary_sync_source_t primary_sync_source_q;
  logic history_q;
  logic [31:0] holdoff_q;
  logic [31:0] st_cnt_q;
  logic fail_q;
  wire logic holdoff_busy = (holdoff_q != 32'h0);
  logic st_ret_q;
  wire logic cmd_take = i_cmd_valid && en_s &&
    state_q != RCS_ST_DISABLED && state_q != RCS_ST_SELFTEST;

  // Pick the target among good references, keeping the current one while it is good
  function automatic rcs_state_t pick(input logic p_ok, input logic s_ok,
                                      input rcs_state_t cur);
    if (cur == RCS_ST_TRACK_PRI && p_ok) begin
      return RCS_ST_TRACK_PRI;
    end else if (cur == RCS_ST_TRACK_SEC && s_ok) begin
      return RCS_ST_TRACK_SEC;
    end else if (p_ok) begin
      return RCS_ST_TRACK_PRI;
    end else if (s_ok) begin
      return RCS_ST_TRACK_SEC;
    end else begin
      return history_q ? RCS_ST_HOLDOVER : RCS_ST_FREERUN;
    end
  endfunction

  rcs_state_t nxt;
  logic auto_sw;
  always_comb begin
    nxt = state_q;
    auto_sw = 1'b0;
    unique case (state_q)
      RCS_ST_DISABLED: begin
        if (en_s) nxt = RCS_ST_SELFTEST;
      end
      RCS_ST_SELFTEST: begin
        if (st_cnt_q == SELFTEST_CYC - 1) nxt = RCS_ST_FREERUN;
      end
      RCS_ST_FREERUN: nxt = RCS_ST_FREERUN;
      RCS_ST_TRACK_PRI, RCS_ST_TRACK_SEC: begin
        if (burst_s) begin
          nxt = history_q ? RCS_ST_HOLDOVER : RCS_ST_FREERUN;
        end else if (!pri_ok && !sec_ok) begin
          nxt = history_q ? RCS_ST_HOLDOVER : RCS_ST_FREERUN;
        end else if (!holdoff_busy) begin
          // Return to the preferred reference once it recovers, if holdover was left on the other one
          if (primary_sync_source_q == RCS_PRIMARY_SYNC_SOURCE_PRI && state_q == RCS_ST_TRACK_SEC &&
              pri_ok && st_ret_q) begin
            nxt = RCS_ST_TRACK_PRI;
          end else if (primary_sync_source_q == RCS_PRIMARY_SYNC_SOURCE_SEC &&
                       state_q == RCS_ST_TRACK_PRI && sec_ok && st_ret_q) begin
            nxt = RCS_ST_TRACK_SEC;
          end else begin
            nxt = pick(pri_ok, sec_ok, state_q);
          end
          auto_sw = (nxt != state_q);
        end
      end
      RCS_ST_HOLDOVER: begin
        if (!burst_s && (pri_ok || sec_ok)) begin
          nxt = pick(pri_ok, sec_ok, state_q);
        end
      end
    endcase
    if (!en_s) nxt = RCS_ST_DISABLED;
  end

  // Remember whether recovery must later return to the preferred side
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ret_q <= 1'b0;
    end else if (cmd_take) begin
      st_ret_q <= 1'b0;
    end else if (state_q == RCS_ST_HOLDOVER && nxt != RCS_ST_HOLDOVER) begin
      st_ret_q <= (primary_sync_source_q == RCS_PRIMARY_SYNC_SOURCE_PRI) ? (nxt == RCS_ST_TRACK_SEC)
                                           : (nxt == RCS_ST_TRACK_PRI);
    end else if (state_q != RCS_ST_HOLDOVER && nxt != state_q) begin
      st_ret_q <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= RCS_ST_DISABLED;
    end else if (cmd_take) begin
      unique case (i_cmd)
        `RCS_CMD_PRI: state_q <= pri_ok ? RCS_ST_TRACK_PRI
                                        : pick(pri_ok, sec_ok, state_q);
        `RCS_CMD_SEC: state_q <= sec_ok ? RCS_ST_TRACK_SEC
                                        : pick(pri_ok, sec_ok, state_q);
        `RCS_CMD_FREE: state_q <= RCS_ST_FREERUN;
        default: state_q <= nxt;
      endcase
    end else begin
      state_q <= nxt;
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      primary_sync_source_q <= RCS_PRIMARY_SYNC_SOURCE_PRI;
    end else if (cmd_take && i_cmd == `RCS_CMD_PRI) begin
      primary_sync_source_q <= RCS_PRIMARY_SYNC_SOURCE_PRI;
    end else if (cmd_take && i_cmd == `RCS_CMD_SEC) begin
      primary_sync_source_q <= RCS_PRIMARY_SYNC_SOURCE_SEC;
    end
  end

  // Quality history exists once any reference was tracked good
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      history_q <= 1'b0;
    end else if (state_q == RCS_ST_DISABLED) begin
      history_q <= 1'b0;
    end else if ((state_q == RCS_ST_TRACK_PRI && pri_ok) ||
                 (state_q == RCS_ST_TRACK_SEC && sec_ok)) begin
      history_q <= 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      holdoff_q <= 32'h0;
    end else if (auto_sw) begin
      holdoff_q <= HOLDOFF_CYC;
    end else if (holdoff_busy) begin
      holdoff_q <= holdoff_q - 32'h1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_cnt_q <= 32'h0;
      fail_q <= 1'b0;
    end else if (state_q == RCS_ST_SELFTEST) begin
      st_cnt_q <= st_cnt_q + 32'h1;
      if (st_cnt_q == SELFTEST_CYC - 1) fail_q <= !st_ok_s;
    end else begin
      st_cnt_q <= 32'h0;
    end
  end

  // Adjust strobe adds the delta in any state; else loop error follows while tracking, 16'h8000 in free-run or disabled, frozen otherwise
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_osc_ctrl <= 16'h8000;
    end else if (i_loop_adjust) begin
      o_osc_ctrl <= o_osc_ctrl + i_loop_delta;
    end else if (state_q == RCS_ST_TRACK_PRI ||
                 state_q == RCS_ST_TRACK_SEC) begin
      o_osc_ctrl <= i_loop_error;
    end else if (state_q == RCS_ST_FREERUN || state_q == RCS_ST_DISABLED) begin
      o_osc_ctrl <= 16'h8000;
    end
  end

  // Line drivers: host card for primary, one configured card for secondary
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_line_drive_en <= 4'h0;
      o_ref_sel_sec <= 1'b0;
      o_ref_sel_ext <= 1'b0;
    end else begin
      o_ref_sel_sec <= (state_q == RCS_ST_TRACK_SEC);
      o_ref_sel_ext <= ext_s;
      if (ext_s || state_q == RCS_ST_DISABLED) begin
        o_line_drive_en <= 4'h0;
      end else if (state_q == RCS_ST_TRACK_SEC) begin
        o_line_drive_en <= 4'h1 << i_sec_card;
      end else begin
        o_line_drive_en <= 4'h1;
      end
    end
  end

  logic [31:0] blink_q;
  logic blink_ph_q;
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      blink_q <= 32'h0;
      blink_ph_q <= 1'b0;
    end else if (blink_q == BLINK_CYC - 1) begin
      blink_q <= 32'h0;
      blink_ph_q <= !blink_ph_q;
    end else begin
      blink_q <= blink_q + 32'h1;
    end
  end

  wire logic locked = (state_q == RCS_ST_TRACK_PRI && pri_ok) ||
                      (state_q == RCS_ST_TRACK_SEC && sec_ok);
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_led_red <= 1'b0;
      o_led_green <= 1'b0;
    end else begin
      o_led_red <= (state_q == RCS_ST_DISABLED);
      o_led_green <= (state_q == RCS_ST_FREERUN) || locked ||
        ((state_q == RCS_ST_TRACK_PRI || state_q == RCS_ST_TRACK_SEC ||
          state_q == RCS_ST_HOLDOVER) && blink_ph_q);
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_status <= 8'h0;
    end else begin
      o_status <= {fail_q, holdoff_busy, history_q, pri_ok, sec_ok,
                   state_q};
    end
  end

  assign o_state = state_q;
  assign o_selftest_fail = fail_q;

  rcs_sanity_timer #(
    .TIMEOUT_CYC(SANITY_CYC)
  ) u_sanity (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(rst_n),
    .i_kick(i_ctrl_kick),
    .o_ctrl_reset(o_ctrl_reset)
  );

  a_holdoff_blocks: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    holdoff_busy && !i_cmd_valid && state_q == RCS_ST_TRACK_SEC && pri_ok &&
    !burst_s && en_s |=> state_q == RCS_ST_TRACK_SEC)
    else $error("automatic switch during hold-off");
  a_both_bad_hold: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    state_q == RCS_ST_TRACK_PRI && !pri_ok && !sec_ok && history_q &&
    en_s && !i_cmd_valid |=> state_q == RCS_ST_HOLDOVER)
    else $error("no holdover with both references bad");
  a_auto_switch: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    state_q == RCS_ST_TRACK_PRI && !pri_ok && sec_ok && !holdoff_busy &&
    !burst_s && en_s && !i_cmd_valid |=> state_q == RCS_ST_TRACK_SEC)
    else $error("no switch to good secondary");
  a_free_stays: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    state_q == RCS_ST_FREERUN && en_s && !i_cmd_valid |=>
    state_q == RCS_ST_FREERUN)
    else $error("left free-run without command");
  a_no_history: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    state_q == RCS_ST_HOLDOVER |-> history_q)
    else $error("holdover without quality history");
  a_one_driver: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    $onehot0(o_line_drive_en))
    else $error("two sources drive the line");
  a_led_red: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    state_q == RCS_ST_DISABLED |=> o_led_red && !o_led_green)
    else $error("led not red when disabled");
  a_selftest_first: assert property (@(posedge i_sys_clk)
    disable iff (!rst_n)
    $past(state_q) == RCS_ST_DISABLED && en_s && state_q != RCS_ST_DISABLED
    |-> state_q == RCS_ST_SELFTEST)
    else $error("tracking began without self-test");
  a_osc_follow: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    state_q == RCS_ST_TRACK_PRI && !i_loop_adjust |=>
    o_osc_ctrl == $past(i_loop_error))
    else $error("loop value not followed");

  c_holdover: cover property (@(posedge i_sys_clk) disable iff (!rst_n)
    state_q == RCS_ST_HOLDOVER ##1 state_q == RCS_ST_TRACK_SEC);
  c_return_pri: cover property (@(posedge i_sys_clk) disable iff (!rst_n)
    state_q == RCS_ST_TRACK_SEC ##1 state_q == RCS_ST_TRACK_PRI);
  c_free_cmd: cover property (@(posedge i_sys_clk) disable iff (!rst_n)
    i_cmd_valid && i_cmd == `RCS_CMD_FREE);
endmodule // rcs_reference_clock_selector
`default_nettype wire

// *** tb/rcs_host_model.sv ***
// Host processor model that issues commands and reads back the status word
`default_nettype none
module rcs_host_model (
  input wire logic i_sys_clk,       // System clock
  input wire logic [7:0] i_status,  // Status word from the selector
  output logic o_cmd_valid,         // Command strobe
  output logic [1:0] o_cmd          // Command code
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] status_q;

  initial begin
    o_cmd_valid = 1'b0;
    o_cmd = 2'h0;
    status_q = 8'h00;
  end

  // Status word is sampled every rising edge, as a polling host would
  always @(posedge i_sys_clk) begin
    status_q <= i_status;
  end

  // Gap lets the host answer promptly or slowly; code scrambled after strobe
  task automatic send(input logic [1:0] c, input int gap);
    repeat (gap) @(negedge i_sys_clk);
    @(negedge i_sys_clk);
    o_cmd_valid = 1'b1;
    o_cmd = c;
    @(negedge i_sys_clk);
    o_cmd_valid = 1'b0;
    o_cmd = ~c;
  endtask
endmodule // rcs_host_model
`default_nettype wire

// *** tb/rcs_reference_clock_selector_tb.sv ***
// Self-checking bench for the reference clock selector
`default_nettype none
`include "rcs_regs.svh"
module rcs_reference_clock_selector_tb;
  import rcs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HO = 50;
  logic clk, rst_n, en, cv, ext, pri, sec, epri, esec, burst, st_ok;
  logic adj, kick, kick_on, sel_sec, sel_ext, st_fail, crst, red, green;
  logic ppres, spres;
  logic [1:0] cmd, card;
  logic [15:0] lerr, ldel, osc, frz;
  logic [3:0] drv;
  logic [7:0] status;
  rcs_state_t state;
  int failures, check_count, kc = 0;
  logic seen0, seen1;

  rcs_reference_clock_selector #(.HOLDOFF_CYC(HO), .SELFTEST_CYC(8),
    .SANITY_CYC(64), .BLINK_CYC(4)) u_rcs_reference_clock_selector (
    .i_sys_clk(clk), .i_reset_n(rst_n), .i_enable(en), .i_cmd_valid(cv),
    .i_cmd(cmd), .i_use_external(ext), .i_sec_card(card),
    .i_pri_in_spec(pri), .i_sec_in_spec(sec), .i_ext_pri_in_spec(epri),
    .i_ext_sec_in_spec(esec), .i_pri_present(ppres),
    .i_sec_present(spres),
    .i_burst(burst), .i_selftest_ok(st_ok), .i_loop_adjust(adj),
    .i_loop_error(lerr), .i_loop_delta(ldel), .i_ctrl_kick(kick),
    .o_state(state), .o_ref_sel_sec(sel_sec), .o_ref_sel_ext(sel_ext),
    .o_line_drive_en(drv), .o_osc_ctrl(osc), .o_status(status),
    .o_selftest_fail(st_fail), .o_ctrl_reset(crst), .o_led_red(red),
    .o_led_green(green));

  rcs_host_model u_rcs_host_model (.i_sys_clk(clk), .i_status(status),
    .o_cmd_valid(cv), .o_cmd(cmd));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Controller service pulses every 16 cycles while kick_on is set
  always @(negedge clk) begin
    kc <= kc + 1;
    kick <= kick_on && (kc % 16 == 0);
  end

  task automatic end_of_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(logic [15:0] got, logic [15:0] exp, string what);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Bounded wait for a state; running out of cycles ends the run
  task automatic wait_st(rcs_state_t e, int bound);
    int n;
    n = 0;
    while (state !== e && n < bound) begin
      @(negedge clk);
      n++;
    end
    check({13'h0, state}, {13'h0, e}, "state");
    if (state !== e) end_of_test();
  endtask

  task automatic hold_st(rcs_state_t e, int cycles);
    repeat (cycles) begin
      @(negedge clk);
      check({13'h0, state}, {13'h0, e}, "state held");
    end
  endtask

  task automatic wait_osc(logic [15:0] e);
    int n;
    n = 0;
    while (osc !== e && n < 10) begin
      @(negedge clk);
      n++;
    end
    check(osc, e, "oscillator value");
  endtask

  // Expected drive enables while tracking a trunk reference
  function automatic logic [3:0] exp_drv(rcs_state_t s);
    return (s == RCS_ST_TRACK_SEC) ? (4'h1 << card) : 4'h1;
  endfunction

  task automatic chk_track(rcs_state_t s);
    repeat (3) @(negedge clk);
    check({12'h0, drv}, {12'h0, exp_drv(s)}, "drive enables");
    check({15'h0, sel_sec}, {15'h0, s == RCS_ST_TRACK_SEC}, "ref select");
  endtask

  task automatic note(string s);
    $display("test done: %s", s);
  endtask

  initial begin
    void'($urandom(32'h2f68b263));
    {rst_n, en, ext, burst, adj, kick_on} = '0;
    {pri, sec, epri, esec, st_ok, ppres, spres} = 7'h7f;
    card = 2'($urandom_range(3, 1));
    lerr = 16'h0000;
    ldel = 16'h0000;
    failures = 0;
    check_count = 0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    check({13'h0, state}, {13'h0, RCS_ST_DISABLED}, "disabled");
    check({15'h0, red}, 16'h1, "red led");
    u_rcs_host_model.send(`RCS_CMD_PRI, 0);
    hold_st(RCS_ST_DISABLED, 5);
    kick_on = 1'b1;
    repeat (20) @(negedge clk);
    repeat (120) begin
      @(negedge clk);
      check({15'h0, crst}, 16'h0, "serviced timer");
    end
    kick_on = 1'b0;
    for (int n = 0; n < 100 && crst !== 1'b1; n++) @(negedge clk);
    repeat (16) begin
      check({15'h0, crst}, 16'h1, "controller reset pulse");
      @(negedge clk);
    end
    check({15'h0, crst}, 16'h0, "reset pulse end");
    kick_on = 1'b1;
    note("disabled and sanity");
    en = 1'b1;
    wait_st(RCS_ST_FREERUN, 40);
    check({15'h0, st_fail}, 16'h0, "self-test");
    check(osc, 16'h8000, "free-run value");
    repeat (10) begin
      @(negedge clk);
      check({14'h0, red, green}, 16'h1, "steady green");
    end
    {burst, pri, sec} = 3'b100;
    hold_st(RCS_ST_FREERUN, 10);
    u_rcs_host_model.send(`RCS_CMD_PRI, 0);
    hold_st(RCS_ST_FREERUN, 6);
    {burst, pri, sec} = 3'b011;
    note("enable");
    u_rcs_host_model.send(`RCS_CMD_PRI, 2);
    wait_st(RCS_ST_TRACK_PRI, 10);
    chk_track(RCS_ST_TRACK_PRI);
    check({10'h0, u_rcs_host_model.status_q[5:0]}, 16'h3b, "status");
    lerr = 16'($urandom);
    wait_osc(lerr);
    pri = 1'b0;
    wait_st(RCS_ST_TRACK_SEC, 10);
    chk_track(RCS_ST_TRACK_SEC);
    check({14'h0, u_rcs_host_model.status_q[4:3]}, 16'h1, "quality");
    {pri, sec} = 2'b10;
    hold_st(RCS_ST_TRACK_SEC, 30);
    wait_st(RCS_ST_TRACK_PRI, HO);
    note("fallback and hold-off");
    frz = osc;
    {pri, sec} = 2'b00;
    wait_st(RCS_ST_HOLDOVER, 10);
    lerr = ~lerr;
    ldel = 16'($urandom_range(255, 1));
    repeat (4) @(negedge clk);
    check(osc, frz, "frozen value");
    adj = 1'b1;
    @(negedge clk);
    adj = 1'b0;
    wait_osc(frz + ldel);
    {seen0, seen1} = 2'b00;
    repeat (12) begin
      @(negedge clk);
      seen0 |= (green === 1'b0);
      seen1 |= (green === 1'b1);
    end
    check({14'h0, seen0, seen1}, 16'h3, "flashing green");
    sec = 1'b1;
    wait_st(RCS_ST_TRACK_SEC, HO + 10);
    pri = 1'b1;
    wait_st(RCS_ST_TRACK_PRI, 2 * HO + 10);
    {pri, sec} = 2'b00;
    wait_st(RCS_ST_HOLDOVER, 10);
    pri = 1'b1;
    wait_st(RCS_ST_TRACK_PRI, HO + 10);
    sec = 1'b1;
    hold_st(RCS_ST_TRACK_PRI, HO + 20);
    note("primary preferred");
    u_rcs_host_model.send(`RCS_CMD_SEC, 0);
    wait_st(RCS_ST_TRACK_SEC, 10);
    sec = 1'b0;
    wait_st(RCS_ST_TRACK_PRI, 2 * HO + 10);
    sec = 1'b1;
    hold_st(RCS_ST_TRACK_PRI, HO + 20);
    {pri, sec} = 2'b00;
    wait_st(RCS_ST_HOLDOVER, 10);
    pri = 1'b1;
    wait_st(RCS_ST_TRACK_PRI, HO + 10);
    sec = 1'b1;
    wait_st(RCS_ST_TRACK_SEC, 2 * HO + 10);
    {pri, sec} = 2'b00;
    wait_st(RCS_ST_HOLDOVER, 10);
    sec = 1'b1;
    wait_st(RCS_ST_TRACK_SEC, HO + 10);
    pri = 1'b1;
    hold_st(RCS_ST_TRACK_SEC, HO + 20);
    note("secondary preferred");
    burst = 1'b1;
    wait_st(RCS_ST_HOLDOVER, 10);
    burst = 1'b0;
    wait_st(RCS_ST_TRACK_SEC, 2 * HO + 10);
    {ppres, spres} = 2'b00;
    wait_st(RCS_ST_HOLDOVER, 10);
    {ppres, spres} = 2'b11;
    wait_st(RCS_ST_TRACK_SEC, 2 * HO + 10);
    note("error burst");
    ext = 1'b1;
    {pri, sec} = 2'b00;
    repeat (6) @(negedge clk);
    check({14'h0, sel_ext, drv == 4'h0}, 16'h3, "external pair");
    check({13'h0, state}, {13'h0, RCS_ST_TRACK_SEC}, "external");
    {ext, pri, sec} = 3'b011;
    note("external pair");
    u_rcs_host_model.send(`RCS_CMD_FREE, 1);
    wait_st(RCS_ST_FREERUN, 10);
    repeat (3) @(negedge clk);
    check(osc, 16'h8000, "free-run value");
    {pri, sec} = 2'b00;
    hold_st(RCS_ST_FREERUN, 8);
    {pri, sec} = 2'b11;
    hold_st(RCS_ST_FREERUN, 8);
    u_rcs_host_model.send(`RCS_CMD_PRI, 0);
    u_rcs_host_model.send(`RCS_CMD_SEC, 0);
    wait_st(RCS_ST_TRACK_SEC, 10);
    note("free run and back-to-back");
    en = 1'b0;
    wait_st(RCS_ST_DISABLED, 10);
    repeat (2) @(negedge clk);
    check({14'h0, red, green}, 16'h2, "red when disabled");
    st_ok = 1'b0;
    en = 1'b1;
    wait_st(RCS_ST_FREERUN, 40);
    check({15'h0, st_fail}, 16'h1, "self-test fail");
    note("self-test failure");
    end_of_test();
  end

  initial begin
    #900us;
    failures++;
    $display("[FAIL] %0t run limit reached", $time);
    end_of_test();
  end
endmodule // rcs_reference_clock_selector_tb
`default_nettype wire
